// ===== pkg/hbps_pkg.sv
// constants for the host bridge function 0 status register block
// assumes one 20 MHz clock and a plain strobe-based register port
//
// Overview of operation
// [RL1] Bit 14 sets when a system error message has gone out on the link, else stays 0.
// [RL2] A system error message is sent only for errors enabled in both command registers.
// [RL3] Bits 14, 13 and 12 clear when software writes 1 to them.
// [RL4] Bit 13 sets when our link request returns an unsupported-request completion.
// [RL5] Bit 12 sets when our link request returns a completer-abort completion.
// [RL6] Bit 11 always reads 0; no target abort or special cycle is ever sent.
// [RL7] Bits 10:9 always read 00, the fast select timing code.
// [RL8] Bit 8, the master parity flag, always reads 0.
// [RL9] Bit 7 always reads 1 to report back-to-back capability.
// [RL10] Bit 5, the 66 MHz flag, always reads 0.
// [RL11] Bit 4 always reads 1 to report a capability list.
// [RL12] Bit 15, the detected parity flag, always reads 0.
// [RL13] Flags reset to 0, hold until cleared, and zero writes or read-only writes do nothing.
package hbps_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_ERR_CMD = 8'h08;
  localparam logic [7:0] OFS_ERR_STS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h14;

  // status register fields
  localparam int ST_DPAR = 15;
  localparam int ST_SERR = 14;
  localparam int ST_UR   = 13;
  localparam int ST_CA   = 12;
  localparam int ST_SA   = 11;
  localparam int ST_TIM  = 9;
  localparam int ST_MPE  = 8;
  localparam int ST_B2B  = 7;
  localparam int ST_66   = 5;
  localparam int ST_CAP  = 4;
  localparam logic [1:0] TIM_FAST = 2'h0;
  localparam logic [15:0] STATUS_RESET = 16'h0090;

  // command register: system error message enable
  localparam int CMD_SERR_EN = 8;
  localparam logic [15:0] COMMAND_MASK = 16'h0100;

  // error status / error command / irq layouts
  localparam int ERR_UR = 0;
  localparam int ERR_CA = 1;
  localparam int ERR_W  = 2;
  localparam int IRQ_UR  = 0;
  localparam int IRQ_CA  = 1;
  localparam int IRQ_SYS = 2;
  localparam int IRQ_W   = 3;

  // completion status codes on the link
  localparam logic [2:0] CPL_SC = 3'h0;
  localparam logic [2:0] CPL_UR = 3'h1;
  localparam logic [2:0] CPL_CA = 3'h4;

  typedef enum logic [1:0] {
    MSG_IDLE = 2'b01,
    MSG_SEND = 2'b10
  } hbps_msg_e;

endpackage

// ===== rtl/hbps_flags.sv
// bank of sticky flags with set and clear vectors
// assumes set and clear come from logic on the same clock
`timescale 1ns/10ps
module hbps_flags #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);

  // set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clr) | set;
    end
  end

endmodule

// ===== rtl/hbps_status.sv
// function 0 status register of the host bridge, with error routing
// assumes completions and message ready arrive from logic on clk
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module hbps_status (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        cpl_valid,
  input  wire logic [2:0]  cpl_status,
  output logic             serr_msg_valid,
  input  wire logic        serr_msg_ready,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////
  // decoding helpers

  // true when the address names the given register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // true when a completion carries the given error code
  function automatic logic cpl_is(input logic v, input logic [2:0] s,
                                  input logic [2:0] code);
    cpl_is = v && (s == code);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // declarations

  logic [15:0]                command;
  logic [hbps_pkg::ERR_W-1:0] err_cmd;
  logic [hbps_pkg::IRQ_W-1:0] irq_mask;
  logic [2:0]                 st_flags;
  logic [2:0]                 st_set;
  logic [2:0]                 st_clr;
  logic [hbps_pkg::ERR_W-1:0] err_sts;
  logic [hbps_pkg::ERR_W-1:0] err_set;
  logic [hbps_pkg::ERR_W-1:0] err_clr;
  logic [hbps_pkg::IRQ_W-1:0] irq_sts;
  logic [hbps_pkg::IRQ_W-1:0] irq_set;
  logic [hbps_pkg::IRQ_W-1:0] irq_clr;
  logic                       ev_ur;
  logic                       ev_ca;
  logic                       serr_req;
  logic                       serr_pend;
  logic                       msg_sent;
  hbps_pkg::hbps_msg_e        msg_state;
  hbps_pkg::hbps_msg_e        next_msg_state;
  logic [15:0]                status_word;
  logic [15:0]                next_rdata;

  //////////////////////////////////////////////////////////////////////
  // link events

  // completion decode for our own requests
  assign ev_ur = cpl_is(cpl_valid, cpl_status, hbps_pkg::CPL_UR);  // [RL4]
  assign ev_ca = cpl_is(cpl_valid, cpl_status, hbps_pkg::CPL_CA);  // [RL5]

  // an error asks for a message only when both enables allow it
  assign serr_req = command[hbps_pkg::CMD_SERR_EN] &&
                    ((ev_ur && err_cmd[hbps_pkg::ERR_UR]) ||
                     (ev_ca && err_cmd[hbps_pkg::ERR_CA]));  // [RL2]

  // the flag follows the handshake, not the request
  assign msg_sent = serr_msg_valid && serr_msg_ready;  // [RL1]

  //////////////////////////////////////////////////////////////////////
  // software registers

  // command register, only the message enable is kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      command <= 16'h0000;
    end else if (reg_wr && hit(reg_addr, hbps_pkg::OFS_COMMAND)) begin
      command <= reg_wdata & hbps_pkg::COMMAND_MASK;
    end
  end

  // per-source message enables
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_cmd <= '0;
    end else if (reg_wr && hit(reg_addr, hbps_pkg::OFS_ERR_CMD)) begin
      err_cmd <= reg_wdata[hbps_pkg::ERR_W-1:0];
    end
  end

  // interrupt mask, same layout as the interrupt status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask <= '0;
    end else if (reg_wr && hit(reg_addr, hbps_pkg::OFS_IRQ_MSK)) begin
      irq_mask <= reg_wdata[hbps_pkg::IRQ_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status flags: bit order message, ur, ca

  assign st_set = {msg_sent, ev_ur, ev_ca};  // [RL1] [RL4] [RL5]

  // only ones written to the three flag positions clear anything
  assign st_clr = (reg_wr && hit(reg_addr, hbps_pkg::OFS_STATUS)) ?
                  {reg_wdata[hbps_pkg::ST_SERR], reg_wdata[hbps_pkg::ST_UR],
                   reg_wdata[hbps_pkg::ST_CA]} : 3'h0;  // [RL3] [RL13]

  hbps_flags #(
    .W (3)
  ) u_st_flags (
    .clk    (clk),
    .resetn (resetn),
    .set    (st_set),
    .clr    (st_clr),
    .flags  (st_flags)
  );  // [RL13]

  // error status mirrors the sources, cleared the same way
  assign err_set = {ev_ca, ev_ur};
  assign err_clr = (reg_wr && hit(reg_addr, hbps_pkg::OFS_ERR_STS)) ?
                   reg_wdata[hbps_pkg::ERR_W-1:0] : '0;

  hbps_flags #(
    .W (hbps_pkg::ERR_W)
  ) u_err_flags (
    .clk    (clk),
    .resetn (resetn),
    .set    (err_set),
    .clr    (err_clr),
    .flags  (err_sts)
  );

  //////////////////////////////////////////////////////////////////////
  // interrupt status, cleared by reading it

  assign irq_set = {msg_sent, ev_ca, ev_ur};
  assign irq_clr = (reg_rd && hit(reg_addr, hbps_pkg::OFS_IRQ_STS)) ?
                   '1 : '0;

  hbps_flags #(
    .W (hbps_pkg::IRQ_W)
  ) u_irq_flags (
    .clk    (clk),
    .resetn (resetn),
    .set    (irq_set),
    .clr    (irq_clr),
    .flags  (irq_sts)
  );

  // level output, one cycle behind the flags so it comes from a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts & irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // system error message sender

  // errors arriving while a message waits are held and sent as one further message after it
  always_comb begin
    next_msg_state = msg_state;
    unique case (msg_state)
      hbps_pkg::MSG_IDLE: begin
        if (serr_req || serr_pend) begin
          next_msg_state = hbps_pkg::MSG_SEND;
        end
      end
      hbps_pkg::MSG_SEND: begin
        if (serr_msg_ready) begin
          next_msg_state = hbps_pkg::MSG_IDLE;
        end
      end
      default: begin
        next_msg_state = hbps_pkg::MSG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msg_state <= hbps_pkg::MSG_IDLE;
    end else begin
      msg_state <= next_msg_state;
    end
  end

  // remembers a request only while one message is already being sent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serr_pend <= 1'b0;
    end else if (msg_state == hbps_pkg::MSG_IDLE) begin
      serr_pend <= 1'b0;
    end else if (serr_req) begin
      serr_pend <= 1'b1;  // [RL2]
    end
  end

  // valid stays high until the link takes the message
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serr_msg_valid <= 1'b0;
    end else begin
      serr_msg_valid <= (next_msg_state == hbps_pkg::MSG_SEND);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status word and read path

  // fixed fields are wired constants; writes never reach them
  always_comb begin
    status_word = 16'h0000;
    status_word[hbps_pkg::ST_DPAR] = 1'b0;  // [RL12]
    status_word[hbps_pkg::ST_SERR] = st_flags[2];  // [RL1]
    status_word[hbps_pkg::ST_UR]  = st_flags[1];  // [RL4]
    status_word[hbps_pkg::ST_CA]  = st_flags[0];  // [RL5]
    status_word[hbps_pkg::ST_SA]  = 1'b0;  // [RL6]
    status_word[hbps_pkg::ST_TIM +: 2] = hbps_pkg::TIM_FAST;  // [RL7]
    status_word[hbps_pkg::ST_MPE] = 1'b0;  // [RL8]
    status_word[hbps_pkg::ST_B2B] = 1'b1;  // [RL9]
    status_word[hbps_pkg::ST_66]  = 1'b0;  // [RL10]
    status_word[hbps_pkg::ST_CAP] = 1'b1;  // [RL11]
  end

  // unmapped addresses read as zero
  always_comb begin
    next_rdata = 16'h0000;
    if (hit(reg_addr, hbps_pkg::OFS_STATUS)) begin
      next_rdata = status_word;
    end else if (hit(reg_addr, hbps_pkg::OFS_COMMAND)) begin
      next_rdata = command;
    end else if (hit(reg_addr, hbps_pkg::OFS_ERR_CMD)) begin
      next_rdata[hbps_pkg::ERR_W-1:0] = err_cmd;
    end else if (hit(reg_addr, hbps_pkg::OFS_ERR_STS)) begin
      next_rdata[hbps_pkg::ERR_W-1:0] = err_sts;
    end else if (hit(reg_addr, hbps_pkg::OFS_IRQ_STS)) begin
      next_rdata[hbps_pkg::IRQ_W-1:0] = irq_sts;
    end else if (hit(reg_addr, hbps_pkg::OFS_IRQ_MSK)) begin
      next_rdata[hbps_pkg::IRQ_W-1:0] = irq_mask;
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// ===== sim/hbps_hub.sv
// far-end hub model: completions on request, message accept after stall
// assumes req and code come from the bench on clk
`timescale 1ns/10ps
module hbps_hub (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       req,
  input  wire logic [2:0] code,
  input  wire logic [1:0] stall,
  input  wire logic       serr_msg_valid,
  output logic            cpl_valid,
  output logic      [2:0] cpl_status,
  output logic            serr_msg_ready
);
  logic [1:0] cnt;
  // completion launch; idle code toggles so a stale code never looks valid
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpl_valid <= 1'b0;
      cpl_status <= 3'h7;
    end else begin
      cpl_valid <= req;
      cpl_status <= req ? code : ~cpl_status;
    end
  end
  // accept a message after stall cycles, ready drops after the handshake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 2'h0;
      serr_msg_ready <= 1'b0;
    end else if (serr_msg_valid && !serr_msg_ready && cnt == stall) begin
      serr_msg_ready <= 1'b1;
    end else if (serr_msg_valid && !serr_msg_ready) begin
      cnt <= cnt + 2'h1;
    end else begin
      serr_msg_ready <= 1'b0;
      cnt <= 2'h0;
    end
  end
endmodule

// ===== sim/hbps_status_asserts.sv
// checker for the function 0 status register block
// assumes it is bound to hbps_status and sees only its ports
`timescale 1ns/10ps
module hbps_chk (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        cpl_valid,
  input wire logic [2:0]  cpl_status,
  input wire logic        serr_msg_valid,
  input wire logic        serr_msg_ready,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////
  // hardwired fields of a status read
  a_zero_bits: assert property (
    reg_rd && reg_addr == 8'h00 |=> (reg_rdata & 16'h8f20) == 16'h0000)
    else $error("status zero field read as one");
  a_one_bits: assert property (
    reg_rd && reg_addr == 8'h00 |=> (reg_rdata & 16'h0090) == 16'h0090)
    else $error("status one field read as zero");
  // read data stands only in the cycle after a read
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  //////////////////////////////////////////////////////////////////////
  // sticky flags seen through the next status read
  a_sse_set: assert property (
    serr_msg_valid && serr_msg_ready ##1 reg_rd && reg_addr == 8'h00 |=> reg_rdata[14])
    else $error("message flag missing");
  a_ur_set: assert property (
    cpl_valid && cpl_status == 3'h1 ##1 reg_rd && reg_addr == 8'h00 |=> reg_rdata[13])
    else $error("unsupported flag missing");
  a_ca_set: assert property (
    cpl_valid && cpl_status == 3'h4 ##1 reg_rd && reg_addr == 8'h00 |=> reg_rdata[12])
    else $error("abort flag missing");
  // completion blocked in the write cycle so set-wins cannot mask a clear
  a_w1c_clear: assert property (
    reg_wr && reg_addr == 8'h00 && reg_wdata[13] && !cpl_valid
    ##1 reg_rd && reg_addr == 8'h00 |=> !reg_rdata[13])
    else $error("flag not cleared by one");
  //////////////////////////////////////////////////////////////////////
  // message request: needs a cause and holds until taken
  a_msg_cause: assert property (
    $rose(serr_msg_valid) |-> $past(cpl_valid) || $past(serr_msg_ready)
    || $past(serr_msg_ready, 2))
    else $error("message without completion");
  a_msg_hold: assert property (
    serr_msg_valid && !serr_msg_ready |=> serr_msg_valid)
    else $error("message dropped before ready");
  c_msg: cover property (serr_msg_valid && serr_msg_ready);
  c_abort: cover property (cpl_valid && cpl_status == 3'h4);
  c_irq: cover property (irq ##1 !irq);
endmodule
bind hbps_status hbps_chk i_chk (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .cpl_valid, .cpl_status, .serr_msg_valid, .serr_msg_ready, .irq);

// ===== sim/tb.sv
// self-checking bench for the status register block
// assumes the hub model drives completions and accepts messages
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module tb;
  logic        clk, resetn, reg_wr, reg_rd, cpl_valid, serr_msg_valid;
  logic        serr_msg_ready, irq, req;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, st, ex_err, ex_irq;
  logic [2:0]  cpl_status, code;
  logic [1:0]  stall;
  int          n_errors, n_tests, n, k;
  int          q[$];
  always #25 clk = ~clk;
  hbps_status i_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cpl_valid, .cpl_status, .serr_msg_valid, .serr_msg_ready, .irq);
  hbps_hub i_hub (.clk, .resetn, .req, .code, .stall, .serr_msg_valid, .cpl_valid,
    .cpl_status, .serr_msg_ready);
  //////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // strobes stay up until the next access, so accesses can be back to back
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    `CHK(reg_rdata, e)
  endtask
  task automatic gap(input int c);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (c) @(posedge clk);
    #1;
  endtask
  // one completion through the hub, then the reference model update
  task automatic send(input logic [2:0] c);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    req <= 1'b1;
    code <= c;
    @(posedge clk);
    #1;
    req <= 1'b0;
    @(posedge clk);
    #1;
    if (c == 3'h1) begin
      st[13] = 1'b1;
      ex_err[0] = 1'b1;
      ex_irq[0] = 1'b1;
    end
    if (c == 3'h4) begin
      st[12] = 1'b1;
      ex_err[1] = 1'b1;
      ex_irq[1] = 1'b1;
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    {clk, resetn, reg_wr, reg_rd, req} = 5'h00;
    {reg_addr, reg_wdata, code, stall} = '0;
    {n_errors, n_tests} = '0;
    {st, ex_err, ex_irq} = {16'h0090, 32'h0};
    void'($urandom(78533));
    repeat (4) @(posedge clk);
    #1;
    resetn <= 1'b1;
    gap(1);
    // reset values, unmapped offset 0x18 included
    for (k = 0; k < 7; k++) rd(8'(k * 4), k == 0 ? 16'h0090 : 16'h0000);
    acc(1'b1, 8'h00, 16'hffff);
    rd(8'h00, st);
    acc(1'b1, 8'h18, 16'hffff);
    rd(8'h18, 16'h0000);
    // completions while reporting is off
    q = '{0, 1, 4};
    foreach (q[i]) begin
      send(3'(q[i]));
      rd(8'h00, st);
    end
    gap(3);
    `CHK(serr_msg_valid, 1'b0)
    `CHK(irq, 1'b0)
    rd(8'h0c, ex_err);
    rd(8'h10, ex_irq);
    ex_irq = 16'h0000;
    acc(1'b1, 8'h00, 16'h0000);
    rd(8'h00, st);
    acc(1'b1, 8'h00, 16'h2000);
    st[13] = 1'b0;
    rd(8'h00, st);
    acc(1'b1, 8'h00, 16'h1000);
    st[12] = 1'b0;
    rd(8'h00, st);
    acc(1'b1, 8'h0c, 16'h0003);
    ex_err = 16'h0000;
    rd(8'h0c, ex_err);
    // reporting and interrupts on, random codes and hub stalls
    acc(1'b1, 8'h04, 16'h0100);
    acc(1'b1, 8'h08, 16'h0003);
    acc(1'b1, 8'h14, 16'h0007);
    rd(8'h04, 16'h0100);
    rd(8'h08, 16'h0003);
    rd(8'h14, 16'h0007);
    for (k = 0; k < 6; k++) begin
      stall <= 2'($urandom % 4);
      send(($urandom % 2) ? 3'h1 : 3'h4);
      for (n = 0; n < 40 && !(serr_msg_valid === 1'b1 && serr_msg_ready === 1'b1); n++) begin
        @(posedge clk);
        #1;
      end
      `CHK(n < 40, 1'b1)
      if (n == 40) close_out();
      @(posedge clk);
      #1;
      st[14] = 1'b1;
      ex_irq[2] = 1'b1;
      rd(8'h00, st);
      `CHK(irq, 1'b1)
      rd(8'h10, ex_irq);
      ex_irq = 16'h0000;
      gap(1);
      `CHK(irq, 1'b0)
      acc(1'b1, 8'h00, 16'h7000);
      acc(1'b1, 8'h0c, 16'h0003);
      {st, ex_err} = {16'h0090, 16'h0000};
      rd(8'h00, st);
    end
    // second cause while the first message waits: exactly one extra message follows
    stall <= 2'h3;
    send(3'h1);
    send(3'h4);
    n = 0;
    repeat (30) begin
      if (serr_msg_valid === 1'b1 && serr_msg_ready === 1'b1) n++;
      @(posedge clk);
      #1;
    end
    `CHK(n, 2)
    st[14] = 1'b1;
    ex_irq[2] = 1'b1;
    rd(8'h00, st);
    rd(8'h10, ex_irq);
    ex_irq = 16'h0000;
    acc(1'b1, 8'h00, 16'h7000);
    st = 16'h0090;
    // abort source not enabled: no message for it
    acc(1'b1, 8'h08, 16'h0001);
    send(3'h4);
    `CHK(serr_msg_valid, 1'b0)
    // completion lands in the clearing write cycle: the set wins
    acc(1'b1, 8'h04, 16'h0000);
    reg_wr <= 1'b0;
    req <= 1'b1;
    code <= 3'h1;
    @(posedge clk);
    #1;
    req <= 1'b0;
    acc(1'b1, 8'h00, 16'h2000);
    {st[13], ex_err[0], ex_irq[0]} = 3'h7;
    rd(8'h00, st);
    // random writes to read-only bits change nothing
    acc(1'b1, 8'h00, 16'($urandom) & 16'h8fff);
    rd(8'h00, st);
    rd(8'h0c, ex_err);
    rd(8'h10, ex_irq);
    gap(2);
    close_out();
  end
endmodule
